/* File: include/wut_defs.vh */
// Purpose: Constants for the wake-up timer: register indices, fields, resets, timing.
// Assumes: Register byte address is four times the register index.
// Notes:   Definitions only; included by bare name.
`ifndef WUT_DEFS_VH
`define WUT_DEFS_VH

// Register indices (byte address = index * 4)
`define WUT_IDX_PRESCALE     10'h316
`define WUT_IDX_CLKARM       10'h317
`define WUT_IDX_RELOAD_LO    10'h318
`define WUT_IDX_RELOAD_HI    10'h319
`define WUT_IDX_CTRL         10'h31A
`define WUT_IDX_IRQ_BANK1    10'h31B
`define WUT_IDX_IRQ_BANK2    10'h31C
`define WUT_IDX_OSC_STATUS   10'h31D
`define WUT_IDX_INT_STATUS   10'h31E
`define WUT_IDX_COUNT_LO     10'h31F
`define WUT_IDX_COUNT_HI     10'h320

// Prescale config fields
`define WUT_PRESCAL_MSB      2
`define WUT_PRESCAL_LSB      0

// Clock/arm config fields
`define WUT_SLEEP_CFG_MSB    6
`define WUT_SLEEP_CFG_LSB    3
`define WUT_SRC_XTAL_BIT     3
`define WUT_CLK_EN_BIT       1
`define WUT_WAKE_ARM_BIT     0

// Timer control fields
`define WUT_FLAG_RST_BIT     0
`define WUT_CAL_TRIG_BIT     1

// Event bits, shared by status and both enable banks
`define WUT_EVT_TIMEOUT_BIT  0
`define WUT_EVT_CAL_BIT      1

// Oscillator status fields
`define WUT_ST_CAL_DONE_BIT  0
`define WUT_ST_FLAG_BIT      1
`define WUT_ST_CAL_BUSY_BIT  2
`define WUT_ST_SLEEP_BIT     3

// Reset values
`define WUT_RST_BYTE         8'h00
`define WUT_RST_EVT          2'h0

// Prescaler terminal counts (divider minus one)
`define WUT_DIV_LAST_0       16'h0000
`define WUT_DIV_LAST_1       16'h0003
`define WUT_DIV_LAST_2       16'h0007
`define WUT_DIV_LAST_3       16'h000F
`define WUT_DIV_LAST_4       16'h007F
`define WUT_DIV_LAST_5       16'h03FF
`define WUT_DIV_LAST_6       16'h1FFF
`define WUT_DIV_LAST_7       16'hFFFF

// Timing
`define WUT_CLK_FREQ_MHZ     10
`define WUT_CAL_TIME_US      1000
`define WUT_CAL_CYCLES       (`WUT_CAL_TIME_US * `WUT_CLK_FREQ_MHZ)

`endif

/* File: core/wut_prescaler.v */
// Purpose: 3-bit programmable prescaler for the wake-up timer.
// Assumes: slow_tick_i is a one-cycle pulse per 32.768 kHz period.
// Notes:   tick_o pulses once every selected number of slow ticks.
`timescale 1ns/100ps
`include "wut_defs.vh"

module wut_prescaler (
    // Clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // Control
    input  wire        clear_i,
    input  wire        slow_tick_i,
    input  wire [2:0]  code_i,
    // Divided tick
    output reg         tick_o
);

    reg  [15:0] div_cnt;
    wire [15:0] last;

    // Terminal count for each prescaler code
    function [15:0] div_last;
        input [2:0] code;
        begin
            case (code)
                3'h0:    div_last = `WUT_DIV_LAST_0;
                3'h1:    div_last = `WUT_DIV_LAST_1;
                3'h2:    div_last = `WUT_DIV_LAST_2;
                3'h3:    div_last = `WUT_DIV_LAST_3;
                3'h4:    div_last = `WUT_DIV_LAST_4;
                3'h5:    div_last = `WUT_DIV_LAST_5;
                3'h6:    div_last = `WUT_DIV_LAST_6;
                default: div_last = `WUT_DIV_LAST_7;
            endcase
        end
    endfunction

    assign last = div_last(code_i);

    // Divider; >= compare so a smaller code mid-count cannot overrun
    always @(posedge clk_i) begin
        if (rst_i || clear_i) begin
            div_cnt <= 16'h0000;
            tick_o  <= 1'b0;
        end else begin
            tick_o <= 1'b0;
            if (slow_tick_i) begin
                if (div_cnt >= last) begin
                    div_cnt <= 16'h0000;
                    tick_o  <= 1'b1;
                end else begin
                    div_cnt <= div_cnt + 16'h0001;
                end
            end
        end
    end

endmodule

/* File: core/wut_top.v */
// Purpose: Sleep wake-up timer with Wishbone register access.
// Assumes: Slow oscillator levels arrive synchronous to clk_i (10 MHz).
// Notes:   Single clock; slow clock edges become one-cycle enables.
//
// Overview of operation
// - The timer runs from a 32.768 kHz source, RC or crystal, picked by the sleep config field.
// - A 3-bit prescaler divides the slow clock by 1, 4, 8, 16, 128, 1024, 8192 or 65536.
// - A 16-bit down counter is driven by the prescaler and reloads from two reload bytes.
// - Once the clock is enabled the counter steps down from the reload value each tick.
// - Reaching zero raises a timeout interrupt where wake-up interrupts are enabled.
// - The timeout interrupt can be enabled in either of two banks, one per interrupt output.
// - With wake-on-expiry armed, the timeout takes the device out of sleep.
// - The RC calibration never starts by itself; a 0 then 1 write of the trigger starts it.
// - Calibration takes about 1 ms and then sets the calibration done flag.
//
// Implementation choice: the Wishbone register port.
`timescale 1ns/100ps
`include "wut_defs.vh"

module wut_top #(
    parameter CAL_CYCLES = `WUT_CAL_CYCLES
) (
    // Clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // Wishbone slave
    input  wire [11:0] wb_adr_i,
    input  wire [31:0] wb_dat_i,
    input  wire [3:0]  wb_sel_i,
    input  wire        wb_we_i,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    // Slow oscillator levels
    input  wire        rc_osc_i,
    input  wire        xtal_osc_i,
    // Radio controller sleep handshake
    input  wire        sleep_cmd_i,
    output reg         sleeping_o,
    output reg         wake_o,
    // Oscillator calibration
    output reg         rc_cal_active_o,
    // Interrupts
    output reg         irq1_o,
    output reg         irq2_o
);

    // Register map, word index on the bus (byte address is four times the index)
    //   0x316  wake_prescale_config   [2:0] prescaler code
    //   0x317  wake_clock_arm_config  [6:3] sleep config, bit 3 picks the crystal
    //                                 bit 1 timer clock enable, bit 0 wake arm
    //   0x318  reload_low_byte        low half of the reload value
    //   0x319  reload_high_byte       high half of the reload value
    //   0x31A  timer control          bit 0 flag reset, bit 1 calibration trigger
    //   0x31B  first_irq_enable_bank  bit 0 timeout, bit 1 calibration done
    //   0x31C  second_irq_enable_bank same layout as the first bank
    //   0x31D  slow_osc_status_reg    bit 0 done, bit 1 flag, bit 2 busy, bit 3 asleep
    //   0x31E  interrupt status       sticky events, write one to clear
    //   0x31F  count low byte         live counter, read only
    //   0x320  count high byte        live counter, read only
    //
    // Only byte lane 0 carries data; the other lanes read back as zero.
    // Indices outside the map are acknowledged, ignored on write, zero on read.
    //
    // Bus timing
    //   A request is taken on the edge that sees cyc and stb high and ack low.
    //   A write lands on that same edge and ack rises with it.
    //   Read data is registered on that edge and stands while ack stands.
    //   Ack lasts one cycle, even if the master keeps stb up.
    //   A master holding stb gets its next access taken once ack has fallen.
    //
    // Timer behaviour
    //   With the clock enable low the counter follows the reload value and the
    //   prescaler is held clear, so enabling always starts a full first tick.
    //   Each prescaler tick steps a nonzero counter down by one.
    //   The tick that brings the counter to zero is the expiry event.
    //   The next tick reloads, so later expiries are reload plus one ticks apart.
    //   A reload of zero expires on every tick.
    //
    // Limitation: the counter bytes are read one at a time and are not latched,
    // so software reading a running counter may see a carry between the halves.
    //
    // Trade-off: the slow oscillators are sampled as plain levels on clk_i; an
    // edge is found by comparing with the previous sample, which costs one cycle
    // of latency but keeps the whole block in a single clock domain.

    // Register storage
    reg  [7:0]  wake_prescale_config;
    reg  [7:0]  wake_clock_arm_config;
    reg  [7:0]  reload_low_byte;
    reg  [7:0]  reload_high_byte;
    reg  [7:0]  timer_ctrl;
    reg  [1:0]  first_irq_enable_bank;
    reg  [1:0]  second_irq_enable_bank;
    reg  [1:0]  int_status;

    // Timer state
    reg         rc_prev;
    reg         xtal_prev;
    reg  [15:0] count;
    reg         timeout_flag;
    reg         rc_cal_done;
    reg  [31:0] cal_cnt;
    reg  [31:0] next_rdata;

    // Decoded access
    wire [9:0]  idx;
    wire        bus_req;
    wire        wr_lane0;
    wire        src_xtal;
    wire        clk_en;
    wire        wake_arm;
    wire        slow_tick;
    wire        presc_tick;
    wire [15:0] reload;
    wire        zero_evt;
    wire        wr_ctrl;
    wire        flag_clr;
    wire        cal_start;
    wire        cal_end;
    wire [1:0]  events;

    assign idx      = wb_adr_i[11:2];
    assign bus_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr_lane0 = bus_req & wb_we_i & wb_sel_i[0];

    // Write strobe for one register index
    function wr_hit;
        input [9:0] at;
        input [9:0] want;
        input       wr;
        begin
            wr_hit = wr && (at == want);
        end
    endfunction

    // Source select and control bits
    assign src_xtal = wake_clock_arm_config[`WUT_SRC_XTAL_BIT];
    assign clk_en   = wake_clock_arm_config[`WUT_CLK_EN_BIT];
    assign wake_arm = wake_clock_arm_config[`WUT_WAKE_ARM_BIT];
    assign reload   = {reload_high_byte, reload_low_byte};

    // Slow clock rising edge of the chosen oscillator
    assign slow_tick = src_xtal ? (xtal_osc_i & ~xtal_prev)
                                : (rc_osc_i & ~rc_prev);

    always @(posedge clk_i) begin
        if (rst_i) begin
            rc_prev   <= 1'b0;
            xtal_prev <= 1'b0;
        end else begin
            rc_prev   <= rc_osc_i;
            xtal_prev <= xtal_osc_i;
        end
    end

    // Prescaler held clear while the timer clock is off
    wut_prescaler u_presc (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .clear_i     (~clk_en),
        .slow_tick_i (slow_tick),
        .code_i      (wake_prescale_config[`WUT_PRESCAL_MSB:`WUT_PRESCAL_LSB]),
        .tick_o      (presc_tick)
    );

    // Zero reached on this tick; a zero reload expires every tick
    assign zero_evt = presc_tick &
                      ((count == 16'h0001) || ((count == 16'h0000) && (reload == 16'h0000)));

    // Down counter; it sits at zero for one tick before reloading
    always @(posedge clk_i) begin
        if (rst_i) begin
            count <= 16'h0000;
        end else if (!clk_en) begin
            count <= reload;
        end else if (presc_tick) begin
            if (count == 16'h0000) begin
                count <= reload;
            end else begin
                count <= count - 16'h0001;
            end
        end
    end

    // Control register edges: flag clear on 1->0, calibration on 0->1
    assign wr_ctrl   = wr_hit(idx, `WUT_IDX_CTRL, wr_lane0);
    assign flag_clr  = wr_ctrl & timer_ctrl[`WUT_FLAG_RST_BIT]
                       & ~wb_dat_i[`WUT_FLAG_RST_BIT];
    assign cal_start = wr_ctrl & ~timer_ctrl[`WUT_CAL_TRIG_BIT]
                       & wb_dat_i[`WUT_CAL_TRIG_BIT];

    // Timeout flag; a new expiry wins over a clear in the same cycle
    always @(posedge clk_i) begin
        if (rst_i) begin
            timeout_flag <= 1'b0;
        end else if (zero_evt) begin
            timeout_flag <= 1'b1;
        end else if (flag_clr) begin
            timeout_flag <= 1'b0;
        end
    end

    // Calibration timer; only software starts it
    // Busy stands for exactly CAL_CYCLES clocks; a new trigger while busy
    // restarts the count and clears the done flag, so a late trigger simply
    // stretches the calibration instead of being lost.
    assign cal_end = rc_cal_active_o && (cal_cnt == 32'd1);

    always @(posedge clk_i) begin
        if (rst_i) begin
            rc_cal_active_o <= 1'b0;
            rc_cal_done     <= 1'b0;
            cal_cnt         <= 32'h00000000;
        end else if (cal_start) begin
            rc_cal_active_o <= 1'b1;
            rc_cal_done     <= 1'b0;
            cal_cnt         <= CAL_CYCLES;
        end else if (rc_cal_active_o) begin
            cal_cnt <= cal_cnt - 32'd1;
            if (cal_end) begin
                rc_cal_active_o <= 1'b0;
                rc_cal_done     <= 1'b1;
            end
        end
    end

    // Sticky interrupt events, write one to clear, set wins
    assign events = {cal_end, zero_evt};

    always @(posedge clk_i) begin
        if (rst_i) begin
            int_status <= `WUT_RST_EVT;
        end else if (wr_hit(idx, `WUT_IDX_INT_STATUS, wr_lane0)) begin
            int_status <= (int_status & ~wb_dat_i[1:0]) | events;
        end else begin
            int_status <= int_status | events;
        end
    end

    // Two enable banks, each feeding its own output
    always @(posedge clk_i) begin
        if (rst_i) begin
            irq1_o <= 1'b0;
            irq2_o <= 1'b0;
        end else begin
            irq1_o <= |(int_status & first_irq_enable_bank);
            irq2_o <= |(int_status & second_irq_enable_bank);
        end
    end

    // Sleep state; an armed expiry ends it
    // The wake pulse needs only the arm bit, not a bank enable, so a masked
    // interrupt still brings the radio back; the expiry wins over a sleep
    // command in the same cycle only while already asleep; an expiry that meets the command while awake is lost.
    always @(posedge clk_i) begin
        if (rst_i) begin
            sleeping_o <= 1'b0;
            wake_o     <= 1'b0;
        end else begin
            wake_o <= 1'b0;
            if (sleeping_o && wake_arm && zero_evt) begin
                sleeping_o <= 1'b0;
                wake_o     <= 1'b1;
            end else if (sleep_cmd_i) begin
                sleeping_o <= 1'b1;
            end
        end
    end

    // Register writes; only byte lane 0 carries data
    always @(posedge clk_i) begin
        if (rst_i) begin
            wake_prescale_config   <= `WUT_RST_BYTE;
            wake_clock_arm_config  <= `WUT_RST_BYTE;
            reload_low_byte        <= `WUT_RST_BYTE;
            reload_high_byte       <= `WUT_RST_BYTE;
            timer_ctrl             <= `WUT_RST_BYTE;
            first_irq_enable_bank  <= 2'h0;
            second_irq_enable_bank <= 2'h0;
        end else if (wr_lane0) begin
            case (idx)
                `WUT_IDX_PRESCALE:  wake_prescale_config   <= wb_dat_i[7:0];
                `WUT_IDX_CLKARM:    wake_clock_arm_config  <= wb_dat_i[7:0];
                `WUT_IDX_RELOAD_LO: reload_low_byte        <= wb_dat_i[7:0];
                `WUT_IDX_RELOAD_HI: reload_high_byte       <= wb_dat_i[7:0];
                `WUT_IDX_CTRL:      timer_ctrl             <= wb_dat_i[7:0];
                `WUT_IDX_IRQ_BANK1: first_irq_enable_bank  <= wb_dat_i[1:0];
                `WUT_IDX_IRQ_BANK2: second_irq_enable_bank <= wb_dat_i[1:0];
                default: ;
            endcase
        end
    end

    // Read multiplexer; unmapped indices read zero
    always @* begin
        next_rdata = 32'h00000000;
        case (idx)
            `WUT_IDX_PRESCALE:   next_rdata[7:0] = wake_prescale_config;
            `WUT_IDX_CLKARM:     next_rdata[7:0] = wake_clock_arm_config;
            `WUT_IDX_RELOAD_LO:  next_rdata[7:0] = reload_low_byte;
            `WUT_IDX_RELOAD_HI:  next_rdata[7:0] = reload_high_byte;
            `WUT_IDX_CTRL:       next_rdata[7:0] = timer_ctrl;
            `WUT_IDX_IRQ_BANK1:  next_rdata[1:0] = first_irq_enable_bank;
            `WUT_IDX_IRQ_BANK2:  next_rdata[1:0] = second_irq_enable_bank;
            `WUT_IDX_OSC_STATUS: begin
                next_rdata[`WUT_ST_CAL_DONE_BIT] = rc_cal_done;
                next_rdata[`WUT_ST_FLAG_BIT]     = timeout_flag;
                next_rdata[`WUT_ST_CAL_BUSY_BIT] = rc_cal_active_o;
                next_rdata[`WUT_ST_SLEEP_BIT]    = sleeping_o;
            end
            `WUT_IDX_INT_STATUS: next_rdata[1:0] = int_status;
            `WUT_IDX_COUNT_LO:   next_rdata[7:0] = count[7:0];
            `WUT_IDX_COUNT_HI:   next_rdata[7:0] = count[15:8];
            default:             next_rdata = 32'h00000000;
        endcase
    end

    // Single-wait-state acknowledge, dropped the cycle after
    // Read data is only updated on read requests, so it holds still across
    // writes and the upper lanes stay zero in every ack cycle.
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= bus_req;
            if (bus_req && !wb_we_i) begin
                wb_dat_o <= next_rdata;
            end
        end
    end

endmodule

/* File: tb/wut_top_properties.sv */
// Purpose: Port-level timing checks for the wake-up timer.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Sees only top-level ports; bound below.
`timescale 1ns/100ps
module wut_props #(
    parameter CAL_CYCLES = 20
) (
    // Clock and reset
    input wire logic        clk_i,
    input wire logic        rst_i,
    // Bus
    input wire logic [11:0] wb_adr_i,
    input wire logic        wb_we_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // Block outputs
    input wire logic        sleeping_o,
    input wire logic        wake_o,
    input wire logic        rc_cal_active_o,
    input wire logic        irq1_o,
    input wire logic        irq2_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    logic [15:0] cal_cnt;

    // Cycles spent calibrating; cleared whenever idle
    always @(posedge clk_i) begin
        cal_cnt <= (rst_i || !rc_cal_active_o) ? 16'h0000 : cal_cnt + 16'h0001;
    end

    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence

    ack_resp_a: assert property (s_req |=> wb_ack_o) else $error("no ack");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i))
        else $error("ack without request");
    rdata_hi_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
        else $error("upper read bits set");
    unmapped_rd_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i[11:2] > 10'h320
        |-> wb_dat_o == 32'h00000000) else $error("unmapped read not zero");
    wake_pulse_a: assert property (wake_o |=> !wake_o) else $error("wake too long");
    wake_exit_a: assert property (wake_o |-> !sleeping_o && $past(sleeping_o))
        else $error("wake without leaving sleep");
    sleep_exit_a: assert property ($fell(sleeping_o) |-> wake_o)
        else $error("sleep left without wake");
    irq_drop_a: assert property ($fell(irq1_o) || $fell(irq2_o)
        |-> $past(wb_ack_o) || $past(rst_i)) else $error("irq fell without write");
    cal_len_a: assert property ($fell(rc_cal_active_o) |-> cal_cnt == CAL_CYCLES)
        else $error("calibration length wrong");
    cal_start_a: assert property ($rose(rc_cal_active_o) |-> wb_ack_o || $past(wb_ack_o))
        else $error("calibration started by itself");
endmodule

bind wut_top wut_props #(.CAL_CYCLES(CAL_CYCLES)) u_props (
    .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_we_i(wb_we_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .sleeping_o(sleeping_o), .wake_o(wake_o), .rc_cal_active_o(rc_cal_active_o),
    .irq1_o(irq1_o), .irq2_o(irq2_o)
);

/* File: tb/wut_testbench.sv */
// Purpose: Self-checking bench for the wake-up timer.
// Assumes: Slow sources run far faster than real to keep runs short.
// Notes:   Shortened calibration time.
`timescale 1ns/100ps
`include "wut_defs.vh"
module testbench;
    localparam CAL = 20;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [11:0] wb_adr_i = 12'h000;
    logic [31:0] wb_dat_i = 32'h00000000;
    logic        wb_we_i = 1'b0;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        rc_osc_i = 1'b0;
    logic        xtal_osc_i = 1'b0;
    logic        sleep_cmd_i = 1'b0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o, sleeping_o, wake_o, rc_cal_active_o, irq1_o, irq2_o;
    logic        run_rc = 1'b1;
    logic        run_x = 1'b0;
    logic        tog = 1'b0;
    logic [31:0] rd;
    int          edges = 0;
    int          mismatches = 0;
    int          tests_run = 0;

    wut_top #(.CAL_CYCLES(CAL)) u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
        .wb_sel_i(4'hF), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rc_osc_i(rc_osc_i),
        .xtal_osc_i(xtal_osc_i), .sleep_cmd_i(sleep_cmd_i), .sleeping_o(sleeping_o),
        .wake_o(wake_o), .rc_cal_active_o(rc_cal_active_o), .irq1_o(irq1_o), .irq2_o(irq2_o)
    );

    initial forever #50 clk_i = ~clk_i;

    // Slow source rises every 4 clocks; a stopped source proves the select
    always @(posedge clk_i) begin
        tog <= ~tog;
        if (tog) begin
            if (run_rc) rc_osc_i <= ~rc_osc_i;
            if (run_x) xtal_osc_i <= ~xtal_osc_i;
            if ((run_rc && !rc_osc_i) || (run_x && !xtal_osc_i)) edges <= edges + 1;
        end
    end

    task automatic tally_and_finish;
        $display("Checks %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %0t %s", $time, msg);
        end
    endtask

    // Classic single access; held until ack is seen at an edge
    task automatic wb(input logic we, input logic [9:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= {idx, 2'b00};
        wb_dat_i <= {24'h000000, d};
        do begin
            @(posedge clk_i);
            n++;
            if (n > 20) begin
                check(32'h0, 32'h1, "no ack");
                tally_and_finish;
            end
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    function automatic logic pick(input int w);
        case (w)
            0: return irq1_o;
            1: return sleeping_o;
            2: return wake_o;
            3: return rc_cal_active_o;
            default: return irq2_o;
        endcase
    endfunction

    // Bounded wait for an output level
    task automatic wait_for(input int w, input logic v, input int lim);
        int n;
        n = 0;
        tests_run++;
        while (pick(w) !== v) begin
            if (n == lim) begin
                check(32'h0, 32'h1, "wait timed out");
                tally_and_finish;
            end
            n++;
            @(posedge clk_i);
        end
    endtask

    // Source first, then reload and prescaler, then flag clear
    task automatic setup(input logic [7:0] src, input logic [7:0] code, input logic [7:0] rl);
        wb(1'b1, `WUT_IDX_CLKARM, src);
        wb(1'b1, `WUT_IDX_RELOAD_LO, rl);
        wb(1'b1, `WUT_IDX_RELOAD_HI, 8'h00);
        wb(1'b1, `WUT_IDX_PRESCALE, code);
        wb(1'b1, `WUT_IDX_CTRL, 8'h01);
        wb(1'b1, `WUT_IDX_CTRL, 8'h00);
        wb(1'b1, `WUT_IDX_INT_STATUS, 8'h03);
    endtask

    task automatic t_regs;
        wb(1'b0, `WUT_IDX_CLKARM, 8'h00);
        check(rd, 32'h0, "config reset");
        wb(1'b0, `WUT_IDX_OSC_STATUS, 8'h00);
        check(rd, 32'h0, "status reset");
        for (int c = 0; c < 8; c++) begin
            wb(1'b1, `WUT_IDX_PRESCALE, 8'(c));
            wb(1'b0, `WUT_IDX_PRESCALE, 8'h00);
            check(rd, 32'(c), "prescale readback");
        end
        wb(1'b0, 10'h3FF, 8'h00);
        check(rd, 32'h0, "unmapped read");
        $display("t_regs done");
    endtask

    task automatic t_prescale;
        int divs[4] = '{1, 4, 8, 16};
        int e0;
        wb(1'b1, `WUT_IDX_IRQ_BANK1, 8'h01);
        for (int c = 0; c < 4; c++) begin
            setup(8'h00, 8'(c), 8'h02);
            wb(1'b1, `WUT_IDX_CLKARM, 8'h02);
            e0 = edges;
            wait_for(0, 1'b1, 300);
            e0 = edges - e0;
            check(32'(e0 >= 2 * divs[c] - 1 && e0 <= 2 * divs[c] + 1), 32'h1, "ticks");
            check(irq2_o, 32'h0, "second bank masked");
            wb(1'b1, `WUT_IDX_CLKARM, 8'h00);
        end
        $display("t_prescale done");
    endtask

    task automatic t_flag;
        wb(1'b0, `WUT_IDX_OSC_STATUS, 8'h00);
        check(rd[1], 32'h1, "flag set");
        wb(1'b1, `WUT_IDX_IRQ_BANK2, 8'h01);
        wait_for(4, 1'b1, 4);
        wb(1'b1, `WUT_IDX_CTRL, 8'h01);
        wb(1'b0, `WUT_IDX_OSC_STATUS, 8'h00);
        check(rd[1], 32'h1, "flag held");
        wb(1'b1, `WUT_IDX_CTRL, 8'h00);
        wb(1'b0, `WUT_IDX_OSC_STATUS, 8'h00);
        check(rd[1], 32'h0, "flag cleared");
        wb(1'b1, `WUT_IDX_INT_STATUS, 8'h01);
        wait_for(0, 1'b0, 4);
        check(irq2_o, 32'h0, "second irq cleared");
        wb(1'b1, `WUT_IDX_IRQ_BANK2, 8'h00);
        $display("t_flag done");
    endtask

    task automatic t_sleep;
        run_rc <= 1'b0;
        run_x  <= 1'b1;
        setup(8'h08, 8'h00, 8'h08);
        wb(1'b1, `WUT_IDX_CLKARM, 8'h0B);
        @(posedge clk_i);
        sleep_cmd_i <= 1'b1;
        @(posedge clk_i);
        sleep_cmd_i <= 1'b0;
        wait_for(1, 1'b1, 4);
        wait_for(2, 1'b1, 200);
        check(sleeping_o, 32'h0, "left sleep");
        wb(1'b1, `WUT_IDX_CLKARM, 8'h00);
        run_x  <= 1'b0;
        run_rc <= 1'b1;
        $display("t_sleep done");
    endtask

    task automatic t_cal;
        wb(1'b1, `WUT_IDX_INT_STATUS, 8'h03);
        wb(1'b1, `WUT_IDX_IRQ_BANK2, 8'h02);
        check(irq2_o, 32'h0, "no calibration yet");
        wb(1'b1, `WUT_IDX_CTRL, 8'h00);
        wb(1'b1, `WUT_IDX_CTRL, 8'h02);
        wait_for(3, 1'b1, 4);
        wait_for(3, 1'b0, CAL + 4);
        wb(1'b0, `WUT_IDX_OSC_STATUS, 8'h00);
        check(rd[0], 32'h1, "calibration done");
        wait_for(4, 1'b1, 4);
        wb(1'b1, `WUT_IDX_INT_STATUS, 8'h02);
        wait_for(4, 1'b0, 4);
        $display("t_cal done");
    endtask

    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs;
        t_prescale;
        t_flag;
        t_sleep;
        t_cal;
        tally_and_finish;
    end
endmodule
